// >>> verilog/spimp_pkg.sv
package spimp_pkg;

  // ==========================================================
  // Register map (word index, byte address = 4 * index)
  localparam logic [7:0] IDX_DATA    = 8'h21;
  localparam logic [7:0] IDX_CONTROL = 8'h22;
  localparam logic [7:0] IDX_STATUS  = 8'h23;
  localparam logic [9:0] ADDR_DATA    = {IDX_DATA, 2'b00};
  localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

  // ==========================================================
  // Field positions and reset values
  localparam int SR_DONE_BIT = 7;
  localparam int SR_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int SR_MODE_FAULT_FLAG_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;

  typedef struct packed {
    logic port_irq_enable;
    logic port_pins_enable;
    logic divide_by_two_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic rate_select_hi;
    logic rate_select_lo;
  } spimp_ctrl_type;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spimp_pins_type;

  typedef enum logic {ST_IDLE, ST_SHIFT} spimp_state_type;

  // ==========================================================
  // Serial clock half periods in processor cycles
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;

  // Every half period doubles when divide_by_two_enable is clear
  function automatic logic [6:0] spimp_half_period(input spimp_ctrl_type c);
    logic [6:0] base;
    base = HALF_DIV4;
    unique case ({c.rate_select_hi, c.rate_select_lo})
      2'b00: base = HALF_DIV4;
      2'b01: base = HALF_DIV8;
      2'b10: base = HALF_DIV32;
      2'b11: base = HALF_DIV64;
    endcase
    return c.divide_by_two_enable ? base : {base[5:0], 1'b0};
  endfunction

endpackage

// >>> verilog/spimp_port.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module spimp_port
  import spimp_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_clk_en,
  input  wire logic              i_halt,
  input  wire logic              i_irq_mask,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic                   o_irq,
  input  wire logic              i_sck,
  output logic                   o_sck,
  output logic                   o_sck_oe,
  input  wire logic              i_mosi,
  output logic                   o_mosi,
  output logic                   o_mosi_oe,
  input  wire logic              i_miso,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  input  wire logic              i_ss_n
);

  // ==========================================================
  // State
  spimp_pins_type  sync1_q, sync2_q;
  logic            sck_dly_q, sck_dly_d;
  spimp_ctrl_type  ctrl_q, ctrl_d;
  spimp_state_type state_q, state_d;
  logic [7:0]      shift_q, shift_d;
  logic [7:0]      rxbuf_q, rxbuf_d;
  logic [6:0]      div_cnt_q, div_cnt_d;
  logic [3:0]      edge_cnt_q, edge_cnt_d;
  logic [2:0]      bit_cnt_q, bit_cnt_d;
  logic            sck_q, sck_d;
  logic            out_bit_q, out_bit_d;
  logic            started_q, started_d;
  logic            done_q, done_d;
  logic            done_arm_q, done_arm_d;
  logic            write_collision_flag_q, write_collision_flag_d;
  logic            write_collision_flag_arm_q, write_collision_flag_arm_d;
  logic            mode_fault_flag_q, mode_fault_flag_d;
  logic            mode_fault_flag_arm_q, mode_fault_flag_arm_d;
  logic [31:0]     prdata_d;
  logic            pready_d, pslverr_d, irq_d;
  logic            sck_oe_d, mosi_oe_d, miso_oe_d;

  // ==========================================================
  // Decode
  logic en, setup, commit, sel_data, sel_ctrl, sel_stat;
  logic wr_data, rd_data, acc_stat, rd_stat, wr_ctrl;
  logic is_master, slave_sel, fault, m_busy, s_busy, busy;
  logic m_edge, s_edge, any_edge, samp, done_ev, wr_ok;

  // Halt freezes everything exactly like a dropped clock enable
  assign en       = i_clk_en & ~i_halt;
  assign setup    = i_psel & ~i_penable;
  assign commit   = i_psel & i_penable & o_pready;
  assign sel_data = i_paddr == ADDR_W'(ADDR_DATA);
  assign sel_ctrl = i_paddr == ADDR_W'(ADDR_CONTROL);
  assign sel_stat = i_paddr == ADDR_W'(ADDR_STATUS);
  assign wr_data  = commit & i_pwrite & sel_data;
  assign rd_data  = commit & ~i_pwrite & sel_data;
  assign acc_stat = commit & sel_stat;
  assign rd_stat  = acc_stat & ~i_pwrite;
  assign wr_ctrl  = commit & i_pwrite & sel_ctrl;

  assign is_master = ctrl_q.port_pins_enable & ctrl_q.master_select;
  assign slave_sel = ctrl_q.port_pins_enable & ~ctrl_q.master_select & ~sync2_q.ss_n;
  // Only a master can fault; a forced slave keeps the flag but never sets it
  assign fault     = ctrl_q.master_select & ~sync2_q.ss_n;
  assign m_busy    = state_q == ST_SHIFT;
  // Phase zero slave has no way to know when the first edge comes
  assign s_busy    = slave_sel & (~ctrl_q.clock_phase | (edge_cnt_q != 4'h0));
  assign busy      = m_busy | s_busy;
  assign m_edge    = m_busy & (div_cnt_q == 7'h00) & ~fault;
  assign s_edge    = slave_sel & (sync2_q.sck ^ sck_dly_q);
  assign any_edge  = m_edge | s_edge;
  // Even edge count means odd edge number; phase zero samples odd edges
  assign samp      = any_edge & (edge_cnt_q[0] == ctrl_q.clock_phase);
  assign done_ev   = samp & (bit_cnt_q == 3'h7);
  assign wr_ok     = wr_data & ~busy & (~done_q | done_arm_q);

  // ==========================================================
  // Next state
  always_comb begin
    spimp_ctrl_type wv;
    wv         = spimp_ctrl_type'(i_pwdata[7:0]);
    sck_dly_d  = sync2_q.sck;
    ctrl_d     = ctrl_q;
    state_d    = state_q;
    shift_d    = shift_q;
    rxbuf_d    = rxbuf_q;
    div_cnt_d  = div_cnt_q;
    edge_cnt_d = edge_cnt_q;
    bit_cnt_d  = bit_cnt_q;
    sck_d      = sck_q;
    out_bit_d  = out_bit_q;
    started_d  = started_q;
    done_d     = done_q;
    done_arm_d = done_arm_q;
    write_collision_flag_d     = write_collision_flag_q;
    write_collision_flag_arm_d = write_collision_flag_arm_q;
    mode_fault_flag_d     = mode_fault_flag_q;
    mode_fault_flag_arm_d = mode_fault_flag_arm_q;

    // Control write; fault-blocked bits only open inside the clearing sequence
    if (wr_ctrl) begin
      if (mode_fault_flag_q && !mode_fault_flag_arm_q) begin
        wv.port_pins_enable = wv.port_pins_enable & ctrl_q.port_pins_enable;
        wv.master_select    = wv.master_select & ctrl_q.master_select;
      end
      ctrl_d = wv;
    end

    // Engine: edges, sampling, byte completion
    if (any_edge) begin
      edge_cnt_d = edge_cnt_q + 4'h1;
    end
    if (samp) begin
      shift_d   = {shift_q[6:0], is_master ? sync2_q.miso : sync2_q.mosi};
      bit_cnt_d = bit_cnt_q + 3'h1;
    end
    if (s_edge) begin
      started_d = 1'b1;
    end
    // Output bit moves on launch edges and accepted data writes, so it holds across the sampling edge
    if (any_edge && !samp) begin
      out_bit_d = shift_q[7];
    end
    if (!slave_sel && !m_busy) begin
      edge_cnt_d = 4'h0;
      bit_cnt_d  = 3'h0;
      started_d  = 1'b0;
    end
    if (!m_busy) begin
      sck_d = ctrl_d.clock_polarity;
    end

    if (m_busy) begin
      if (div_cnt_q == 7'h00) begin
        div_cnt_d = spimp_half_period(ctrl_q) - 7'h01;
        sck_d     = ~sck_q;
        if (edge_cnt_q == 4'hF) begin
          state_d = ST_IDLE;
        end
      end else begin
        div_cnt_d = div_cnt_q - 7'h01;
      end
    end

    // Accepted data write loads the shift register; master starts
    if (wr_ok) begin
      shift_d = i_pwdata[7:0];
      out_bit_d = i_pwdata[7];
      if (is_master) begin
        state_d    = ST_SHIFT;
        div_cnt_d  = spimp_half_period(ctrl_q) - 7'h01;
        edge_cnt_d = 4'h0;
        bit_cnt_d  = 3'h0;
      end
    end

    // Done flag: clear by status access then data access, set wins
    if (acc_stat && done_q) begin
      done_arm_d = 1'b1;
    end
    if ((rd_data || wr_data) && done_arm_q) begin
      done_d     = 1'b0;
      done_arm_d = 1'b0;
    end
    if (done_ev) begin
      done_d = 1'b1;
      // Later bytes are dropped silently while done is pending
      if (!done_q) begin
        rxbuf_d = {shift_q[6:0], is_master ? sync2_q.miso : sync2_q.mosi};
      end
    end

    // Collision flag: status read then data read clears, write does not
    if (rd_stat && write_collision_flag_q) begin
      write_collision_flag_arm_d = 1'b1;
    end
    if (rd_data && write_collision_flag_arm_q) begin
      write_collision_flag_d     = 1'b0;
      write_collision_flag_arm_d = 1'b0;
    end
    if (wr_data && busy) begin
      write_collision_flag_d = 1'b1;
    end

    // Mode fault flag and its clearing sequence
    if (acc_stat && mode_fault_flag_q) begin
      mode_fault_flag_arm_d = 1'b1;
    end
    if (wr_ctrl && mode_fault_flag_arm_q) begin
      mode_fault_flag_d     = 1'b0;
      mode_fault_flag_arm_d = 1'b0;
    end
    if (fault) begin
      mode_fault_flag_d                  = 1'b1;
      ctrl_d.port_pins_enable = 1'b0;
      ctrl_d.master_select    = 1'b0;
      state_d                 = ST_IDLE;
    end
  end

  // ==========================================================
  // Bus answer and pins, all registered
  always_comb begin
    prdata_d  = 32'h0000_0000;
    pready_d  = setup;
    pslverr_d = setup & ~(sel_data | sel_ctrl | sel_stat);
    if (setup && !i_pwrite) begin
      if (sel_data) begin
        prdata_d[7:0] = rxbuf_q;
      end else if (sel_ctrl) begin
        prdata_d[7:0] = ctrl_q;
      end else if (sel_stat) begin
        prdata_d[SR_DONE_BIT] = done_q;
        prdata_d[SR_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_q;
        prdata_d[SR_MODE_FAULT_FLAG_BIT] = mode_fault_flag_q;
      end
    end
    // The same line wakes the processor from wait
    irq_d     = ~i_irq_mask & ctrl_d.port_irq_enable & (done_d | mode_fault_flag_d);
    sck_oe_d  = ctrl_d.port_pins_enable & ctrl_d.master_select;
    mosi_oe_d = sck_oe_d;
    miso_oe_d = slave_sel & ~fault & (~ctrl_q.clock_phase | started_d);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sync1_q    <= '1;
      sync2_q    <= '1;
      sck_dly_q  <= 1'b0;
      ctrl_q     <= spimp_ctrl_type'(CONTROL_RESET);
      state_q    <= ST_IDLE;
      shift_q    <= DATA_RESET;
      rxbuf_q    <= DATA_RESET;
      div_cnt_q  <= 7'h00;
      edge_cnt_q <= 4'h0;
      bit_cnt_q  <= 3'h0;
      sck_q      <= 1'b0;
      out_bit_q  <= 1'b0;
      started_q  <= 1'b0;
      done_q     <= 1'b0;
      done_arm_q <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
      o_prdata   <= 32'h0000_0000;
      o_pready   <= 1'b0;
      o_pslverr  <= 1'b0;
      o_irq      <= 1'b0;
      o_sck_oe   <= 1'b0;
      o_mosi_oe  <= 1'b0;
      o_miso_oe  <= 1'b0;
    end else if (en) begin
      sync1_q    <= '{sck: i_sck, mosi: i_mosi, miso: i_miso, ss_n: i_ss_n};
      sync2_q    <= sync1_q;
      sck_dly_q  <= sck_dly_d;
      ctrl_q     <= ctrl_d;
      state_q    <= state_d;
      shift_q    <= shift_d;
      rxbuf_q    <= rxbuf_d;
      div_cnt_q  <= div_cnt_d;
      edge_cnt_q <= edge_cnt_d;
      bit_cnt_q  <= bit_cnt_d;
      sck_q      <= sck_d;
      out_bit_q  <= out_bit_d;
      started_q  <= started_d;
      done_q     <= done_d;
      done_arm_q <= done_arm_d;
      write_collision_flag_q     <= write_collision_flag_d;
      write_collision_flag_arm_q <= write_collision_flag_arm_d;
      mode_fault_flag_q     <= mode_fault_flag_d;
      mode_fault_flag_arm_q <= mode_fault_flag_arm_d;
      o_prdata   <= prdata_d;
      o_pready   <= pready_d;
      o_pslverr  <= pslverr_d;
      o_irq      <= irq_d;
      o_sck_oe   <= sck_oe_d;
      o_mosi_oe  <= mosi_oe_d;
      o_miso_oe  <= miso_oe_d;
    end
  end

  // Data pins come straight from the launched output bit
  assign o_sck  = sck_q;
  assign o_mosi = out_bit_q;
  assign o_miso = out_bit_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_mode_fault_flag_set;
    en && ctrl_q.master_select && !sync2_q.ss_n |=> mode_fault_flag_q;
  endproperty
  a_mode_fault_flag_set: assert property (p_mode_fault_flag_set) else $error("fault flag not set");

  property p_fault_disables;
    en && fault |=> !ctrl_q.port_pins_enable && !ctrl_q.master_select && !m_busy;
  endproperty
  a_fault_disables: assert property (p_fault_disables) else $error("fault left port on");

  property p_no_mode_fault_flag_slave;
    !ctrl_q.master_select && !mode_fault_flag_q |=> !mode_fault_flag_q;
  endproperty
  a_no_mode_fault_flag_slave: assert property (p_no_mode_fault_flag_slave) else $error("fault set as slave");

  property p_blocked_write;
    en && mode_fault_flag_q && !mode_fault_flag_arm_q && wr_ctrl && !ctrl_q.port_pins_enable
      |=> !ctrl_q.port_pins_enable;
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("enable set in fault");

  property p_irq_cause;
    o_irq |-> $past(done_q || mode_fault_flag_q || done_d || mode_fault_flag_d);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

  property p_irq_masked;
    en && i_irq_mask |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");

  property p_collision;
    en && wr_data && busy && !samp |=> write_collision_flag_q && shift_q == $past(shift_q);
  endproperty
  a_collision: assert property (p_collision) else $error("collision mishandled");

  property p_rx_keep;
    en && done_ev && done_q |=> rxbuf_q == $past(rxbuf_q) && done_q;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("buffer overwritten");

  property p_done_set;
    en && done_ev && !done_q |=> done_q && rxbuf_q == $past(shift_d);
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not raised");

  property p_miso_hidden;
    en && ctrl_q.clock_phase && !started_q && !s_edge |=> !o_miso_oe;
  endproperty
  a_miso_hidden: assert property (p_miso_hidden) else $error("MSB driven early");

  c_master_byte: cover property (en && m_busy && done_ev);
  c_slave_byte:  cover property (en && slave_sel && done_ev);
  c_fault:       cover property (en && fault && ctrl_q.port_pins_enable);

endmodule // spimp_port

// >>> verif/spimp_peer.sv
`timescale 1ns/1ps
// ==========================================================
// Behavioural external slave on the serial link
module spimp_peer (
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_ss_n,
  input  wire logic       i_cpol,
  input  wire logic       i_cpha,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] sh_q  = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic       ss_q  = 1'b1;

  // One process owns every output, so each line has a single driver
  always @(i_sck or i_ss_n) begin
    if (i_ss_n !== ss_q) begin
      ss_q = i_ss_n;
      if (!i_ss_n) begin
        sh_q = i_tx;
        cnt_q = 4'h0;
        if (!i_cpha) begin
          o_miso = i_tx[7];
        end
      end else begin
        // Released line has no pull: show a changed level, never the last bit
        o_miso = ~o_miso;
      end
    end else if (!i_ss_n && ((i_sck != i_cpol) ^ i_cpha)) begin
      sh_q = {sh_q[6:0], i_mosi};
      cnt_q = cnt_q + 4'h1;
      if (cnt_q == 4'h8) begin
        o_rx = sh_q;
        cnt_q = 4'h0;
      end
    end else if (!i_ss_n) begin
      o_miso = sh_q[7];
    end
  end
endmodule // spimp_peer

// >>> verif/spi_master_slave_port_tb.sv
`timescale 1ns/1ps
module spi_master_slave_port_tb
  import spimp_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, halt = 1'b0, mask = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ss_n = 1'b1, sel_n = 1'b1, ssck = 1'b0, err;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, sck, sck_oe, mosi, mosi_oe;
  logic        miso, miso_oe, peer_miso, s;
  logic [7:0]  ptx = 8'h00, prx, dtx, ctl;
  int          num_errors = 0, num_checks = 0;

  always #4 clk = ~clk;

  spimp_port i_dut (.i_clk(clk), .i_resetn(resetn), .i_clk_en(1'b1), .i_halt(halt),
    .i_irq_mask(mask), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .i_sck(ssck), .o_sck(sck), .o_sck_oe(sck_oe),
    .i_mosi(1'b0), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .i_miso(peer_miso),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_ss_n(ss_n));

  spimp_peer i_peer (.i_sck(sck), .i_mosi(mosi), .i_ss_n(sel_n), .i_cpol(ctl[3]),
    .i_cpha(ctl[2]), .i_tx(ptx), .o_miso(peer_miso), .o_rx(prx));

  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    // One access cycle is the contracted answer time
    chk(32'(n), 32'h0000_0000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1'b1);
  endtask

  task automatic conclude;
    $display("Checks made %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    conclude();
  end

  // ==========================================================
  // Scenarios
  initial begin
    ctl = 8'h00;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdchk(ADDR_CONTROL, 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_DATA, 8'h00);
    apb(1'b1, 10'h3F0, 8'h5A);
    chk(err, 1'b1);
    // Every polarity and phase, with a collision and a halt mid-byte
    for (int m = 0; m < 4; m++) begin
      ctl = 8'hF1 | {4'h0, 2'(m), 2'b00};
      dtx = 8'h3C + 8'(m);
      ptx <= 8'hA5 - 8'(m);
      apb(1'b1, ADDR_CONTROL, ctl);
      sel_n <= 1'b0;
      chk({sck_oe, mosi_oe}, 2'b11);
      apb(1'b1, ADDR_DATA, dtx);
      apb(1'b1, ADDR_DATA, 8'hFF);
      chk(irq, 1'b0);
      halt <= 1'b1;
      @(posedge clk);
      s = sck;
      repeat (10) @(posedge clk);
      chk(sck, s);
      halt <= 1'b0;
      wait_irq();
      mask <= 1'b1;
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      mask <= 1'b0;
      apb(1'b1, ADDR_DATA, 8'h55);
      rdchk(ADDR_STATUS, 8'hC0);
      chk(prx, dtx);
      rdchk(ADDR_DATA, 8'hA5 - 8'(m));
      rdchk(ADDR_STATUS, 8'h00);
      chk(sck, ctl[3]);
      sel_n <= 1'b1;
    end
    // Mode fault
    apb(1'b1, ADDR_CONTROL, 8'hD1);
    ss_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(irq, 1'b1);
    chk({sck_oe, mosi_oe}, 2'b00);
    rdchk(ADDR_CONTROL, 8'h81);
    apb(1'b1, ADDR_CONTROL, 8'hD1);
    rdchk(ADDR_CONTROL, 8'h81);
    ss_n <= 1'b1;
    rdchk(ADDR_STATUS, 8'h10);
    apb(1'b1, ADDR_CONTROL, 8'hD1);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_CONTROL, 8'hD1);
    // Slave, phase zero: select low freezes data
    apb(1'b1, ADDR_CONTROL, 8'h40);
    ss_n <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(ADDR_STATUS, 8'h00);
    apb(1'b1, ADDR_DATA, 8'h11);
    rdchk(ADDR_STATUS, 8'h40);
    apb(1'b1, ADDR_DATA, 8'h22);
    rdchk(ADDR_STATUS, 8'h40);
    chk(miso, 1'b1);
    ss_n <= 1'b1;
    rdchk(ADDR_DATA, 8'hA2);
    rdchk(ADDR_STATUS, 8'h00);
    // Slave, phase one: no output before the first edge
    apb(1'b1, ADDR_CONTROL, 8'h44);
    ss_n <= 1'b0;
    apb(1'b1, ADDR_DATA, 8'h80);
    repeat (6) @(posedge clk);
    chk(miso_oe, 1'b0);
    ssck <= 1'b1;
    repeat (6) @(posedge clk);
    chk(miso_oe, 1'b1);
    chk(miso, 1'b1);
    apb(1'b1, ADDR_DATA, 8'h00);
    chk(miso, 1'b1);
    rdchk(ADDR_STATUS, 8'h40);
    ss_n <= 1'b1;
    ssck <= 1'b0;
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule // spi_master_slave_port_tb
